// [src/arpct_pkg.sv]
/*
  Package for the autoreload PWM capture timer: register offsets, field
  positions, reset values, clock select codes and the shared carrier struct.
  Assumes an 8-bit register port with byte-wide registers at consecutive byte offsets.
*/
package arpct_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 6;

  // ----------------------------------------------------------------
  // Register offsets (byte index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_STAT = 6'h0d;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 6'h0e;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 6'h0f;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_HI = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LO = 6'h11;
  localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 6'h12;
  localparam logic [ADDR_W-1:0] OFS_CH_CS0 = 6'h13;
  localparam logic [ADDR_W-1:0] OFS_DUTY0_HI = 6'h17;
  localparam logic [ADDR_W-1:0] OFS_CAP_HI = 6'h1f;
  localparam logic [ADDR_W-1:0] OFS_CAP_LO = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_XFER_CTRL = 6'h21;
  localparam logic [ADDR_W-1:0] OFS_SHUT_CTRL = 6'h22;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS_CAP_FLAG = 6;
  localparam int CS_CAP_IE = 5;
  localparam int CS_CLK_HI = 4;
  localparam int CS_CLK_LO = 3;
  localparam int CS_OVF_FLAG = 2;
  localparam int CS_OVF_IE = 1;
  localparam int CS_CMP_IE = 0;
  localparam int CH_POL = 1;
  localparam int CH_CMP_FLAG = 0;
  localparam int SD_ACTIVE = 5;
  localparam int SD_IN_EN = 4;
  localparam int XF_EN = 0;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic XFER_RST = 1'b1;

  // Clock select codes
  typedef enum logic [1:0] {
    CLK_OFF = 2'h0,
    CLK_LITE = 2'h1,
    CLK_CPU = 2'h2,
    CLK_FAST = 2'h3
  } arpct_clk_e;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } arpct_req_s;

endpackage

// [src/arpct_sync2.sv]
/*
  Two-flip-flop synchroniser for a vector of asynchronous pins.
  Assumes the pins are levels that stay stable for several clocks.
*/
`timescale 1ns/100ps
module arpct_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      meta_ff <= rst_val_in;
      sync_ff <= rst_val_in;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// [src/arpct_timer.sv]
/*
  Autoreload PWM capture timer: 12-bit up-counter with reload, four PWM
  channels with shadowed duty and polarity, emergency shutdown, input capture.
  Assumes a single-cycle 8-bit register port, read data one cycle after the
  read strobe, and tick enables from outside on core_clk_in.
*/
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
module arpct_timer
  import arpct_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic lite_tick_in,
  input wire logic cpu_tick_in,
  input wire logic fast_tick_in,
  input wire logic capture_input_pin_in,
  input wire logic shutdown_n_in,
  output logic [7:0] reg_rdata_out,
  output logic [NCH-1:0] modulated_output_out,
  output logic [NCH-1:0] pwm_pin_oe_n_out,
  output logic ovf_irq_out,
  output logic cap_cmp_irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  arpct_req_s req;
  logic [CNT_W-1:0] counter_value_ff;
  logic [CNT_W-1:0] reload_value_ff;
  logic [CNT_W-1:0] capture_value_ff;
  logic [CNT_W-1:0] duty_value_ff [NCH];
  logic [CNT_W-1:0] duty_shadow_ff [NCH];
  logic [NCH-1:0] channel_polarity_ff;
  logic [NCH-1:0] pol_shadow_ff;
  logic [NCH-1:0] channel_compare_flag_ff;
  logic [NCH-1:0] out_en_ff;
  logic [NCH-1:0] pin_owned_ff;
  logic [NCH-1:0] wave_ff;
  logic [3:0] cnt_hi_latch_ff;
  logic [1:0] clock_select_ff;
  logic capture_flag_ff;
  logic capture_irq_enable_ff;
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  logic compare_irq_enable_ff;
  logic shutdown_active_ff;
  logic shutdown_input_enable_ff;
  logic [3:0] shutdown_pattern_ff;
  logic xfer_en_ff;
  logic cap_prev_ff;
  logic [1:0] pins_sync;
  logic tick;
  logic ovf_evt;
  logic cap_evt;
  logic pwm_ok;
  logic [NCH-1:0] match;
  logic [CNT_W-1:0] nxt_count;
  int rd_ci;
  int rd_di;
  int rd_li;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // Channel index of a per-channel register, or NCH when none
  function automatic int ch_of(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int step);
    int d;
    d = int'(a) - int'(base);
    if (d >= 0 && d < NCH * step && (d % step) == 0) begin
      return d / step;
    end
    return NCH;
  endfunction

  function automatic logic wr_at(input arpct_req_s r, input logic [ADDR_W-1:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_at(input arpct_req_s r, input logic [ADDR_W-1:0] a);
    return r.rd && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  arpct_sync2 #(.W(2)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({capture_input_pin_in, shutdown_n_in}),
    .rst_val_in(2'h3),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Tick selection by clock select field
  always_comb begin
    case (arpct_clk_e'(clock_select_ff))
      CLK_OFF: tick = 1'b0;
      CLK_LITE: tick = lite_tick_in;
      CLK_CPU: tick = cpu_tick_in;
      CLK_FAST: tick = fast_tick_in;
      default: tick = 1'b0;
    endcase
  end

  assign ovf_evt = tick && (counter_value_ff == CNT_MAX);
  assign pwm_ok = (arpct_clk_e'(clock_select_ff) != CLK_LITE);
  // Count that the next tick lands on, so a match drops the wave while the counter shows the duty value
  assign nxt_count = ovf_evt ? reload_value_ff : counter_value_ff + 12'h001;

  // Count up, wrap to reload; shutdown forces reset value
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || shutdown_active_ff) begin
      counter_value_ff <= CNT_ZERO;
    end else if (ovf_evt) begin
      counter_value_ff <= reload_value_ff;
    end else if (tick) begin
      counter_value_ff <= counter_value_ff + 12'h001;
    end
  end

  // Reload register pair
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || shutdown_active_ff) begin
      reload_value_ff <= CNT_ZERO;
    end else if (wr_at(req, OFS_RELOAD_HI)) begin
      reload_value_ff[11:8] <= req.wdata[3:0];
    end else if (wr_at(req, OFS_RELOAD_LO)) begin
      reload_value_ff[7:0] <= req.wdata;
    end
  end

  // High nibble latched by low-byte read
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cnt_hi_latch_ff <= 4'h0;
    end else if (rd_at(req, OFS_CNT_LO)) begin
      cnt_hi_latch_ff <= counter_value_ff[11:8];
    end
  end

  // ----------------------------------------------------------------
  // Control status flags
  // ----------------------------------------------------------------
  // Control and enables
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      capture_irq_enable_ff <= 1'b0;
      clock_select_ff <= 2'h0;
      overflow_irq_enable_ff <= 1'b0;
      compare_irq_enable_ff <= 1'b0;
    end else if (wr_at(req, OFS_CTRL_STAT)) begin
      capture_irq_enable_ff <= req.wdata[CS_CAP_IE];
      clock_select_ff <= {req.wdata[CS_CLK_HI], req.wdata[CS_CLK_LO]};
      overflow_irq_enable_ff <= req.wdata[CS_OVF_IE];
      compare_irq_enable_ff <= req.wdata[CS_CMP_IE];
    end
  end

  // Overflow flag, set wins over read clear
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      overflow_flag_ff <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_ff <= 1'b1;
    end else if (rd_at(req, OFS_CTRL_STAT)) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  assign cap_evt = (pins_sync[1] != cap_prev_ff) && !capture_flag_ff;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cap_prev_ff <= 1'b1;
    end else begin
      cap_prev_ff <= pins_sync[1];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      capture_value_ff <= CNT_ZERO;
    end else if (cap_evt) begin
      capture_value_ff <= counter_value_ff;
    end
  end

  // Capture flag; writes have no effect, set wins over read clear
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      capture_flag_ff <= 1'b0;
    end else if (cap_evt) begin
      capture_flag_ff <= 1'b1;
    end else if (rd_at(req, OFS_CAP_HI) || rd_at(req, OFS_CAP_LO)) begin
      capture_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown and transfer control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      shutdown_active_ff <= 1'b0;
      shutdown_input_enable_ff <= 1'b0;
      shutdown_pattern_ff <= 4'h0;
    end else begin
      if (wr_at(req, OFS_SHUT_CTRL)) begin
        shutdown_input_enable_ff <= req.wdata[SD_IN_EN];
        shutdown_pattern_ff <= req.wdata[3:0];
      end
      if (shutdown_input_enable_ff && !pins_sync[0]) begin
        shutdown_active_ff <= 1'b1;
      end else if (wr_at(req, OFS_SHUT_CTRL)) begin
        shutdown_active_ff <= req.wdata[SD_ACTIVE];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      xfer_en_ff <= XFER_RST;
    end else if (ovf_evt && xfer_en_ff) begin
      xfer_en_ff <= 1'b0;
    end else if (wr_at(req, OFS_XFER_CTRL)) begin
      xfer_en_ff <= req.wdata[XF_EN];
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign match[c] = tick && (nxt_count == duty_shadow_ff[c]) && (duty_shadow_ff[c] != CNT_ZERO);

    // Duty registers and shadows, cleared by shutdown
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || shutdown_active_ff) begin
        duty_value_ff[c] <= CNT_ZERO;
        duty_shadow_ff[c] <= CNT_ZERO;
      end else begin
        if (wr_at(req, OFS_DUTY0_HI + ADDR_W'(2 * c))) begin
          duty_value_ff[c][11:8] <= req.wdata[3:0];
        end else if (wr_at(req, OFS_DUTY0_HI + ADDR_W'(2 * c + 1))) begin
          duty_value_ff[c][7:0] <= req.wdata;
        end
        if (ovf_evt && xfer_en_ff) begin
          duty_shadow_ff[c] <= duty_value_ff[c];
        end
      end
    end

    // Polarity and shadow
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        channel_polarity_ff[c] <= 1'b0;
        pol_shadow_ff[c] <= 1'b0;
      end else begin
        if (wr_at(req, OFS_CH_CS0 + ADDR_W'(c))) begin
          channel_polarity_ff[c] <= req.wdata[CH_POL];
        end
        if (ovf_evt && xfer_en_ff) begin
          pol_shadow_ff[c] <= channel_polarity_ff[c];
        end
      end
    end

    // Compare flag; set wins over status read clear
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        channel_compare_flag_ff[c] <= 1'b0;
      end else if (match[c] && pwm_ok) begin
        channel_compare_flag_ff[c] <= 1'b1;
      end else if (rd_at(req, OFS_CH_CS0 + ADDR_W'(c))) begin
        channel_compare_flag_ff[c] <= 1'b0;
      end
    end

    // Raw waveform: high at overflow, low on match
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || shutdown_active_ff) begin
        wave_ff[c] <= 1'b0;
      end else if (ovf_evt) begin
        wave_ff[c] <= 1'b1;
      end else if (match[c]) begin
        wave_ff[c] <= 1'b0;
      end
    end

    // Output enable cleared by shutdown; pin ownership released at overflow once disabled, or at once with lite clock
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || shutdown_active_ff) begin
        out_en_ff[c] <= 1'b0;
      end else if (wr_at(req, OFS_OUT_CTRL)) begin
        out_en_ff[c] <= req.wdata[2 * c];
      end
    end

    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        pin_owned_ff[c] <= 1'b0;
      end else if (shutdown_active_ff) begin
        pin_owned_ff[c] <= 1'b1;
      end else if (out_en_ff[c] && pwm_ok) begin
        pin_owned_ff[c] <= 1'b1;
      end else if (ovf_evt || !pwm_ok) begin
        pin_owned_ff[c] <= 1'b0;
      end
    end

    // Pin drive: pattern in shutdown, else polarity applied
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        modulated_output_out[c] <= 1'b0;
        pwm_pin_oe_n_out[c] <= 1'b1;
      end else begin
        pwm_pin_oe_n_out[c] <= !pin_owned_ff[c];
        if (shutdown_active_ff) begin
          modulated_output_out[c] <= shutdown_pattern_ff[c];
        end else begin
          modulated_output_out[c] <= wave_ff[c] ^ pol_shadow_ff[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ovf_irq_out <= 1'b0;
      cap_cmp_irq_out <= 1'b0;
    end else begin
      ovf_irq_out <= overflow_flag_ff && overflow_irq_enable_ff;
      cap_cmp_irq_out <= (capture_flag_ff && capture_irq_enable_ff)
        || (|channel_compare_flag_ff && compare_irq_enable_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Channel index of the addressed per-channel register
  assign rd_ci = ch_of(req.addr, OFS_CH_CS0, 1);
  assign rd_di = ch_of(req.addr, OFS_DUTY0_HI, 2);
  assign rd_li = ch_of(req.addr, OFS_DUTY0_HI + 6'h01, 2);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= RST_BYTE;
    end else if (!req.rd) begin
      reg_rdata_out <= RST_BYTE;
    end else if (rd_ci < NCH) begin
      reg_rdata_out <= {6'h00, channel_polarity_ff[rd_ci], channel_compare_flag_ff[rd_ci]};
    end else if (rd_di < NCH) begin
      reg_rdata_out <= {4'h0, duty_value_ff[rd_di][11:8]};
    end else if (rd_li < NCH) begin
      reg_rdata_out <= duty_value_ff[rd_li][7:0];
    end else begin
      case (req.addr)
        OFS_CTRL_STAT: reg_rdata_out <= {1'b0, capture_flag_ff, capture_irq_enable_ff, clock_select_ff,
                                         overflow_flag_ff, overflow_irq_enable_ff, compare_irq_enable_ff};
        OFS_CNT_HI: reg_rdata_out <= {4'h0, cnt_hi_latch_ff};
        OFS_CNT_LO: reg_rdata_out <= counter_value_ff[7:0];
        OFS_RELOAD_HI: reg_rdata_out <= {4'h0, reload_value_ff[11:8]};
        OFS_RELOAD_LO: reg_rdata_out <= reload_value_ff[7:0];
        OFS_OUT_CTRL: reg_rdata_out <= {1'b0, out_en_ff[3], 1'b0, out_en_ff[2], 1'b0, out_en_ff[1], 1'b0, out_en_ff[0]};
        OFS_CAP_HI: reg_rdata_out <= {4'h0, capture_value_ff[11:8]};
        OFS_CAP_LO: reg_rdata_out <= capture_value_ff[7:0];
        OFS_XFER_CTRL: reg_rdata_out <= {7'h00, xfer_en_ff};
        OFS_SHUT_CTRL: reg_rdata_out <= {2'h0, shutdown_active_ff, shutdown_input_enable_ff,
                                         shutdown_pattern_ff};
        default: reg_rdata_out <= RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ovf_sets_flag: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ovf_evt |=> overflow_flag_ff) else $error("overflow flag not set");
  a_cnt_wraps_reload: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ovf_evt && !shutdown_active_ff |=> counter_value_ff == $past(reload_value_ff)) else $error("no reload");
  a_cnt_holds_off: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    clock_select_ff == 2'h0 && !shutdown_active_ff |=> $stable(counter_value_ff)) else $error("counter moved");
  a_cap_flag_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    capture_flag_ff |=> $stable(capture_value_ff)) else $error("capture while flag set");
  a_cap_flag_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_at(req, OFS_CAP_LO) && !cap_evt |=> !capture_flag_ff) else $error("capture flag not cleared");
  a_shut_pattern: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    shutdown_active_ff |=> modulated_output_out == $past(shutdown_pattern_ff)) else $error("pattern not forced");
  a_shut_pin_sets: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !shutdown_input_enable_ff |=> !$rose(shutdown_active_ff) || $past(wr_at(req, OFS_SHUT_CTRL)))
    else $error("shutdown set while disabled");
  a_shut_top_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rd_at(req, OFS_SHUT_CTRL) |=> reg_rdata_out[7:6] == 2'h0) else $error("top bits not zero");
  a_ovf_irq_gate: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !overflow_irq_enable_ff ##1 !overflow_irq_enable_ff |-> !ovf_irq_out) else $error("irq while masked");
  a_xfer_clears: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ovf_evt && xfer_en_ff |=> !xfer_en_ff) else $error("transfer bit not cleared");

endmodule

// [bench/arpct_far_model.sv]
/*
  Far-side model: the capture signal source and the converter's trip line.
  Assumes the bench flips the capture pin by one-cycle requests and holds trip as a level, both on core_clk_in.
*/
`timescale 1ns/100ps
module arpct_far_model (
  input wire logic core_clk_in,
  input wire logic cap_toggle_in,
  input wire logic trip_in,
  output logic cap_pin_out,
  output logic shutdown_n_out
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Both lines idle high, the level the design's synchroniser assumes at reset
  logic cap_q = 1'b1;
  logic shut_q = 1'b1;
  // Each request flips the capture pin, giving both edge kinds in turn
  always_ff @(posedge core_clk_in) begin
    if (cap_toggle_in) begin
      cap_q <= ~cap_q;
    end
    shut_q <= ~trip_in; // Trip pulls the line low
  end
  assign cap_pin_out = cap_q;
  assign shutdown_n_out = shut_q;
endmodule

// [bench/testbench.sv]
/*
  Self-checking bench for the timer: register tasks and one task a scenario.
  Assumes the register port and tick enables share core_clk_in at 40 MHz.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import arpct_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_tick = 1'b1;
  logic tie_low = 1'b0;
  logic cap_toggle = 1'b0;
  logic trip = 1'b0;
  logic cap_pin, shut_n, ovf_irq, cc_irq;
  logic [7:0] rdata, lo;
  logic [3:0] pwm, oe_n;
  int checks = 0;
  int bad_count = 0;
  int cycles = 0;
  int hi0, hi1;
  // ----------------------------------------------------------------
  // Clock, instances and hang guard
  // ----------------------------------------------------------------
  initial forever #12.5 core_clk_in = ~core_clk_in;
  arpct_timer arpct_timer_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .lite_tick_in(cpu_tick), .cpu_tick_in(cpu_tick), .fast_tick_in(tie_low),
    .capture_input_pin_in(cap_pin), .shutdown_n_in(shut_n), .reg_rdata_out(rdata),
    .modulated_output_out(pwm), .pwm_pin_oe_n_out(oe_n), .ovf_irq_out(ovf_irq),
    .cap_cmp_irq_out(cc_irq));
  arpct_far_model arpct_far_model_inst (.core_clk_in(core_clk_in), .cap_toggle_in(cap_toggle),
    .trip_in(trip), .cap_pin_out(cap_pin), .shutdown_n_out(shut_n));
  // Cuts a hang short well past the longest scenario
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    `CHK(d, e)
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(OFS_CTRL_STAT, 8'h00);
    rd_chk(OFS_XFER_CTRL, 8'h01);
    rd_chk(OFS_CNT_LO, 8'h00);
    rd_chk(6'h3f, 8'h00);
    `CHK(oe_n, 4'hf)
  endtask
  task automatic t_soft_shutdown();
    reg_write(OFS_SHUT_CTRL, 8'hff);
    rd_chk(OFS_SHUT_CTRL, 8'h3f);
    `CHK(pwm, 4'hf)
    reg_write(OFS_SHUT_CTRL, 8'h00);
  endtask
  // Period of 16 ticks; channel 1 inverted with a later match
  task automatic t_pwm();
    reg_write(OFS_RELOAD_HI, 8'h0f);
    reg_write(OFS_RELOAD_LO, 8'hf0);
    reg_write(OFS_DUTY0_HI, 8'h0f);
    reg_write(OFS_DUTY0_HI + 6'h01, 8'hf8);
    reg_write(OFS_DUTY0_HI + 6'h02, 8'h0f);
    reg_write(OFS_DUTY0_HI + 6'h03, 8'hfc);
    reg_write(OFS_CH_CS0 + 6'h01, 8'h02);
    reg_write(OFS_OUT_CTRL, 8'h05);
    reg_write(OFS_XFER_CTRL, 8'h01);
    reg_write(OFS_CTRL_STAT, 8'h11);
    wait_clk(4200);
    hi0 = 0;
    hi1 = 0;
    for (int i = 0; i < 32; i++) begin
      wait_clk(1);
      hi0 += pwm[0];
      hi1 += pwm[1];
    end
    `CHK(hi0, 16)
    `CHK(hi1, 8)
    `CHK(oe_n[1:0], 2'h0)
    `CHK(cc_irq, 1'b1)
    rd_chk(OFS_CH_CS0, 8'h01);
    rd_chk(OFS_CH_CS0 + 6'h01, 8'h03);
  endtask
  // Lite tick keeps the counter running, yet pins are released and no compare flag sets
  task automatic t_lite();
    reg_write(OFS_CTRL_STAT, 8'h08);
    wait_clk(2);
    `CHK(oe_n[1:0], 2'h3)
    reg_read(OFS_CH_CS0, lo);
    rd_chk(OFS_CH_CS0, 8'h00);
  endtask
  task automatic t_overflow();
    reg_write(OFS_CTRL_STAT, 8'h02);
    wait_clk(1);
    `CHK(ovf_irq, 1'b1)
    rd_chk(OFS_CTRL_STAT, 8'h06);
    rd_chk(OFS_CTRL_STAT, 8'h02);
    `CHK(ovf_irq, 1'b0)
    reg_read(OFS_CNT_LO, lo);
    rd_chk(OFS_CNT_HI, 8'h0f);
  endtask
  // Counter stopped, so the captured value equals the last read
  task automatic t_capture();
    reg_write(OFS_CTRL_STAT, 8'h20);
    @(posedge core_clk_in);
    cap_toggle <= 1'b1;
    @(posedge core_clk_in);
    cap_toggle <= 1'b0;
    wait_clk(6);
    `CHK(cc_irq, 1'b1)
    rd_chk(OFS_CTRL_STAT, 8'h60);
    rd_chk(OFS_CAP_LO, lo);
    rd_chk(OFS_CTRL_STAT, 8'h20);
  endtask
  task automatic t_trip();
    reg_write(OFS_SHUT_CTRL, 8'h0a);
    trip <= 1'b1;
    wait_clk(6);
    rd_chk(OFS_SHUT_CTRL, 8'h0a);
    reg_write(OFS_SHUT_CTRL, 8'h1a);
    wait_clk(6);
    rd_chk(OFS_SHUT_CTRL, 8'h3a);
    `CHK(pwm, 4'ha)
    rd_chk(OFS_CNT_LO, 8'h00);
    rd_chk(OFS_OUT_CTRL, 8'h00);
    trip <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_n <= 1'b1;
    t_reset();
    t_soft_shutdown();
    t_pwm();
    t_lite();
    t_overflow();
    t_capture();
    t_trip();
    tally_and_finish();
  end
endmodule
